// ===== verilog/srnvg_top.sv
// Reset-cause, system NMI and user NMI vector generators with read-to-clear
// What this block does
// - Reset-cause vector at 015Eh, 00h when idle
// - Brownout 02h, reset pin 04h, software brownout 06h
// - Deep-sleep wake 08h, security 0Ah, high supervisor 0Eh
// - Software power-on 14h; 0Ch,10h,12h never reported
// - Watchdog expiry 16h, watchdog key 18h
// - Memory controller key 1Ah, uncorrectable 1Ch
// - Peripheral area fetch reported as 1Eh
// - Power key 20h, lock loss 24h, rest reserved
// - System NMI at 015Ch: supervisor 02h, uncorrectable 04h
// - Vacant access 12h, mailbox input 14h
// - Mailbox output 16h; 1Ah-1Eh reserved
// - Correctable memory error 18h after mailbox
// - User NMI at 015Ah: pin 02h, oscillator 04h
// - Manage resets, NMI sources and vector values
// - Mailbox events from debug link raise flags
`timescale 1ns/1ps
`default_nettype none

module srnvg_top
  import srnvg_pkg::*;
(
  // Clock and reset (reset is the brownout-class reset)
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  // CPU bus, word reads only affect vectors
  input  wire logic [ADDR_W-1:0] BUS_ADDR,
  input  wire logic              BUS_RD,
  output var  logic [DATA_W-1:0] BUS_RDATA,
  output var  logic              BUS_HIT,
  // Reset cause events, one-cycle pulses
  input  wire logic [RST_N-1:0]  RESET_CAUSE_EVENT,
  // System NMI events
  input  wire logic              SVS_LOWPOWER_ENTRY,
  input  wire logic              NVM_UNCORR_ERROR,
  input  wire logic              VACANT_ACCESS,
  input  wire logic              MAILBOX_IN_EVENT,
  input  wire logic              MAILBOX_OUT_EVENT,
  input  wire logic              NVM_CORR_ERROR,
  // User NMI events
  input  wire logic              NMI_PIN_EVENT,
  input  wire logic              OSC_FAULT_EVENT,
  // Pending status
  output var  logic              SYS_NMI_PENDING,
  output var  logic              USER_NMI_PENDING
);

  typedef enum logic [1:0] {
    SRNVG_SEL_NONE = 2'b00,
    SRNVG_SEL_USER = 2'b01,
    SRNVG_SEL_SYS  = 2'b10,
    SRNVG_SEL_RST  = 2'b11
  } srnvg_sel_t;

  logic [RST_N-1:0]  rst_flag;
  logic [RST_N-1:0]  next_rst_flag;
  logic [SNMI_N-1:0] snmi_flag;
  logic [SNMI_N-1:0] next_snmi_flag;
  logic [UNMI_N-1:0] unmi_flag;
  logic [UNMI_N-1:0] next_unmi_flag;
  logic [DATA_W-1:0] next_rdata;
  logic              next_hit;
  logic              next_snmi_pend;
  logic              next_unmi_pend;
  logic [SNMI_N-1:0] snmi_event;
  logic [UNMI_N-1:0] unmi_event;
  logic [DATA_W-1:0] rst_vec;
  logic [DATA_W-1:0] snmi_vec;
  logic [DATA_W-1:0] unmi_vec;
  logic [RST_N-1:0]  rst_onehot;
  logic [SNMI_N-1:0] snmi_onehot;
  logic [UNMI_N-1:0] unmi_onehot;
  srnvg_sel_t        sel;

  // Lowest pending index gives lowest code
  function automatic logic [DATA_W-1:0] srnvg_encode(input logic [31:0] flags,
                                                       input int unsigned n);
    logic [DATA_W-1:0] code;
    code = VEC_NONE;
    for (int i = 31; i >= 0; i--) begin
      if (i < n && flags[i]) begin
        code = DATA_W'((i + 1) * 2);
      end
    end
    return code;
  endfunction

  always_comb begin
    snmi_event = '0;
    snmi_event[SN_SVS_LP]     = SVS_LOWPOWER_ENTRY;
    snmi_event[SN_NVM_UNCORR] = NVM_UNCORR_ERROR;
    snmi_event[SN_VACANT]     = VACANT_ACCESS;
    snmi_event[SN_MBOX_IN]    = MAILBOX_IN_EVENT;
    snmi_event[SN_MBOX_OUT]   = MAILBOX_OUT_EVENT;
    snmi_event[SN_NVM_CORR]   = NVM_CORR_ERROR;
    unmi_event[UN_NMI_PIN]    = NMI_PIN_EVENT;
    unmi_event[UN_OSC_FAULT]  = OSC_FAULT_EVENT;
  end

  always_comb begin
    rst_vec  = srnvg_encode(32'(rst_flag), RST_N);
    snmi_vec = srnvg_encode(32'(snmi_flag), SNMI_N);
    unmi_vec = srnvg_encode(32'(unmi_flag), UNMI_N);
  end

  // Address decode of the three read-only vectors
  always_comb begin
    sel = SRNVG_SEL_NONE;
    if (BUS_RD) begin
      case (BUS_ADDR)
        RST_CAUSE_OFFSET: sel = SRNVG_SEL_RST;
        SYS_NMI_OFFSET:   sel = SRNVG_SEL_SYS;
        USER_NMI_OFFSET:  sel = SRNVG_SEL_USER;
        default:          sel = SRNVG_SEL_NONE;
      endcase
    end
  end

  // One-hot of the reported cause, used to clear it on read
  always_comb begin
    rst_onehot  = '0;
    snmi_onehot = '0;
    unmi_onehot = '0;
    if (rst_vec != VEC_NONE) begin
      rst_onehot[rst_vec[5:1] - 5'h01] = 1'b1;
    end
    if (snmi_vec != VEC_NONE) begin
      snmi_onehot[snmi_vec[4:1] - 4'h1] = 1'b1;
    end
    if (unmi_vec != VEC_NONE) begin
      unmi_onehot[unmi_vec[1] ? 0 : 1] = 1'b1;
    end
  end

  // Reset causes: clear the reported one on its read, then set new events.
  // Setting after clearing keeps an event that lands in the read cycle.
  always_comb begin
    next_rst_flag = rst_flag;
    if (sel == SRNVG_SEL_RST) begin
      next_rst_flag = rst_flag & ~rst_onehot;
    end
    // Reserved codes are masked so they can never be reported
    next_rst_flag = next_rst_flag | (RESET_CAUSE_EVENT & RST_VALID_MASK);
  end

  // RST is the brownout-class reset, so brownout is recorded as the cause.
  // Other causes arrive as events while the logic stays alive.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rst_flag <= RST_N'(1) << RC_BROWNOUT;
    end else begin
      rst_flag <= next_rst_flag;
    end
  end

  // System NMI causes, same clear-then-set order as the reset causes
  always_comb begin
    next_snmi_flag = snmi_flag;
    if (sel == SRNVG_SEL_SYS) begin
      next_snmi_flag = snmi_flag & ~snmi_onehot;
    end
    next_snmi_flag = next_snmi_flag | (snmi_event & SNMI_VALID_MASK);
    // Pending follows the flags after this edge's update
    next_snmi_pend = |next_snmi_flag;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      snmi_flag       <= '0;
      SYS_NMI_PENDING <= 1'b0;
    end else begin
      snmi_flag       <= next_snmi_flag;
      SYS_NMI_PENDING <= next_snmi_pend;
    end
  end

  // User NMI causes
  always_comb begin
    next_unmi_flag = unmi_flag;
    if (sel == SRNVG_SEL_USER) begin
      next_unmi_flag = unmi_flag & ~unmi_onehot;
    end
    next_unmi_flag = next_unmi_flag | (unmi_event & UNMI_VALID_MASK);
    next_unmi_pend = |next_unmi_flag;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      unmi_flag        <= '0;
      USER_NMI_PENDING <= 1'b0;
    end else begin
      unmi_flag        <= next_unmi_flag;
      USER_NMI_PENDING <= next_unmi_pend;
    end
  end

  // Read data: the vector as it stood before the clear of this read
  always_comb begin
    next_rdata = VEC_NONE;
    next_hit   = 1'b0;
    case (sel)
      SRNVG_SEL_RST: begin
        next_rdata = rst_vec;
        next_hit   = 1'b1;
      end
      SRNVG_SEL_SYS: begin
        next_rdata = snmi_vec;
        next_hit   = 1'b1;
      end
      SRNVG_SEL_USER: begin
        next_rdata = unmi_vec;
        next_hit   = 1'b1;
      end
      default: begin
        next_rdata = VEC_NONE;
        next_hit   = 1'b0;
      end
    endcase
  end

  // Data stands one cycle only, so a missed sample cannot be re-read
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BUS_RDATA <= VEC_RESET;
      BUS_HIT   <= 1'b0;
    end else begin
      BUS_RDATA <= next_rdata;
      BUS_HIT   <= next_hit;
    end
  end

endmodule

`default_nettype wire

// ===== pkg/srnvg_pkg.sv
// Package of offsets, cause codes and widths for the reset and NMI vector generator
package srnvg_pkg;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 16;
  localparam logic [15:0] USER_NMI_OFFSET = 16'h015A;
  localparam logic [15:0] SYS_NMI_OFFSET  = 16'h015C;
  localparam logic [15:0] RST_CAUSE_OFFSET = 16'h015E;
  localparam logic [15:0] VEC_NONE        = 16'h0000;
  localparam logic [15:0] VEC_RESET       = 16'h0000;
  // Reset-cause flag indices; vector code is 2*(index+1)
  localparam int unsigned RST_N = 18;
  localparam int unsigned RC_BROWNOUT   = 0;
  localparam int unsigned RC_RESET_PIN  = 1;
  localparam int unsigned RC_SW_BOR     = 2;
  localparam int unsigned RC_DEEP_WAKE  = 3;
  localparam int unsigned RC_SECURITY   = 4;
  localparam int unsigned RC_RSVD_0C    = 5;
  localparam int unsigned RC_HIGH_SVS   = 6;
  localparam int unsigned RC_RSVD_10    = 7;
  localparam int unsigned RC_RSVD_12    = 8;
  localparam int unsigned RC_SW_POR     = 9;
  localparam int unsigned RC_WDT_EXP    = 10;
  localparam int unsigned RC_WDT_KEY    = 11;
  localparam int unsigned RC_NVM_KEY    = 12;
  localparam int unsigned RC_NVM_UNCORR = 13;
  localparam int unsigned RC_PERIPH_FETCH = 14;
  localparam int unsigned RC_PMM_KEY    = 15;
  localparam int unsigned RC_RSVD_22    = 16;
  localparam int unsigned RC_FLL_UNLOCK = 17;
  // Reserved positions never set
  localparam logic [17:0] RST_VALID_MASK = 18'h2FE5F;
  // System NMI flag indices
  localparam int unsigned SNMI_N = 12;
  localparam int unsigned SN_SVS_LP     = 0;
  localparam int unsigned SN_NVM_UNCORR = 1;
  localparam int unsigned SN_VACANT     = 8;
  localparam int unsigned SN_MBOX_IN    = 9;
  localparam int unsigned SN_MBOX_OUT   = 10;
  localparam int unsigned SN_NVM_CORR   = 11;
  localparam logic [11:0] SNMI_VALID_MASK = 12'hF03;
  // User NMI flag indices
  localparam int unsigned UNMI_N = 2;
  localparam int unsigned UN_NMI_PIN  = 0;
  localparam int unsigned UN_OSC_FAULT = 1;
  localparam logic [1:0]  UNMI_VALID_MASK = 2'h3;
  // Brownout-class cause positions (codes 02h-0Ah, 0Eh); no logic uses this mask to clear causes
  localparam logic [17:0] BOR_CLASS_MASK = 18'h0005F;
endpackage

// ===== verif/srnvg_props.sv
// Checker of read timing and vector code ranges
`timescale 1ns/1ps
`default_nettype none
module srnvg_props
  import srnvg_pkg::*;
(
  input wire logic              SYS_CLK,
  input wire logic              RST,
  input wire logic [ADDR_W-1:0] BUS_ADDR,
  input wire logic              BUS_RD,
  input wire logic [DATA_W-1:0] BUS_RDATA,
  input wire logic              BUS_HIT,
  input wire logic              SVS_LOWPOWER_ENTRY,
  input wire logic              NMI_PIN_EVENT,
  input wire logic              OSC_FAULT_EVENT,
  input wire logic              SYS_NMI_PENDING,
  input wire logic              USER_NMI_PENDING
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic map;
  assign map = BUS_ADDR inside {USER_NMI_OFFSET, SYS_NMI_OFFSET, RST_CAUSE_OFFSET};
  a_read_hit: assert property (BUS_RD && map |=> BUS_HIT) else $error("mapped read missed");
  a_unmapped_quiet: assert property (!(BUS_RD && map) |=> !BUS_HIT && BUS_RDATA == 16'h0000)
    else $error("output without mapped read");
  a_code_even: assert property (BUS_HIT |-> !BUS_RDATA[0] && BUS_RDATA[15:6] == 10'h000)
    else $error("vector code not even");
  a_rsvd_absent: assert property (BUS_HIT && $past(BUS_ADDR) == RST_CAUSE_OFFSET
    |-> !(BUS_RDATA[7:0] inside {8'h0C, 8'h10, 8'h12, 8'h22})) else $error("reserved reset code");
  a_sys_codes: assert property (BUS_HIT && $past(BUS_ADDR) == SYS_NMI_OFFSET
    |-> BUS_RDATA[7:0] inside {8'h00, 8'h02, 8'h04, 8'h12, 8'h14, 8'h16, 8'h18}) else $error("bad sys code");
  a_user_codes: assert property (BUS_HIT && $past(BUS_ADDR) == USER_NMI_OFFSET
    |-> BUS_RDATA[7:0] inside {8'h00, 8'h02, 8'h04}) else $error("bad user code");
  a_boot_brownout: assert property ($fell(RST) ##1 (BUS_RD && BUS_ADDR == RST_CAUSE_OFFSET)
    |=> BUS_RDATA == 16'h0002) else $error("brownout not first after reset");
  a_svs_first: assert property (SVS_LOWPOWER_ENTRY ##1 !BUS_RD ##1
    (BUS_RD && BUS_ADDR == SYS_NMI_OFFSET) |=> BUS_RDATA == 16'h0002) else $error("svs not first");
  a_user_pend: assert property (NMI_PIN_EVENT || OSC_FAULT_EVENT |=> USER_NMI_PENDING)
    else $error("user pending missing");
  a_sys_pend: assert property (SVS_LOWPOWER_ENTRY |=> SYS_NMI_PENDING) else $error("sys pending missing");
endmodule
bind srnvg_top srnvg_props srnvg_props_inst (.SYS_CLK(SYS_CLK), .RST(RST), .BUS_ADDR(BUS_ADDR),
  .BUS_RD(BUS_RD), .BUS_RDATA(BUS_RDATA), .BUS_HIT(BUS_HIT), .SVS_LOWPOWER_ENTRY(SVS_LOWPOWER_ENTRY),
  .NMI_PIN_EVENT(NMI_PIN_EVENT), .OSC_FAULT_EVENT(OSC_FAULT_EVENT),
  .SYS_NMI_PENDING(SYS_NMI_PENDING), .USER_NMI_PENDING(USER_NMI_PENDING));
`default_nettype wire

// ===== verif/srnvg_test.sv
// Self-checking bench for the reset and NMI vector generator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin total_checks++; if ((g) !== (w)) begin n_mismatch++; $display("Error at %0t: got %h want %h", $time, g, w); end end
module srnvg_test
  import srnvg_pkg::*;
;
  logic        SYS_CLK = 1'b0;
  logic        RST = 1'b1;
  logic [15:0] BUS_ADDR = 16'h0000;
  logic        BUS_RD = 1'b0;
  logic [17:0] rc = '0;
  logic [5:0]  sn = '0;
  logic [1:0]  un = '0;
  logic [15:0] BUS_RDATA;
  logic        BUS_HIT, SYS_NMI_PENDING, USER_NMI_PENDING, rd_d = 1'b0;
  logic [16:0] q[$];
  logic [16:0] expv;
  int          n_mismatch = 0, total_checks = 0, i;
  integer      seed = 32'h420ab481;
  logic [31:0] r;
  logic [7:0]  sc [6] = '{8'h02, 8'h04, 8'h12, 8'h14, 8'h16, 8'h18};
  always #5 SYS_CLK = ~SYS_CLK;
  srnvg_top srnvg_top_inst (.SYS_CLK(SYS_CLK), .RST(RST), .BUS_ADDR(BUS_ADDR), .BUS_RD(BUS_RD),
    .BUS_RDATA(BUS_RDATA), .BUS_HIT(BUS_HIT), .RESET_CAUSE_EVENT(rc), .SVS_LOWPOWER_ENTRY(sn[0]),
    .NVM_UNCORR_ERROR(sn[1]), .VACANT_ACCESS(sn[2]), .MAILBOX_IN_EVENT(sn[3]),
    .MAILBOX_OUT_EVENT(sn[4]), .NVM_CORR_ERROR(sn[5]), .NMI_PIN_EVENT(un[0]),
    .OSC_FAULT_EVENT(un[1]), .SYS_NMI_PENDING(SYS_NMI_PENDING), .USER_NMI_PENDING(USER_NMI_PENDING));
  // Reads may follow back to back; the note of the result goes in with the request
  task rd(input logic [15:0] a, input logic [7:0] c, input logic h);
    @(posedge SYS_CLK); BUS_RD <= 1'b1; BUS_ADDR <= a; q.push_back({h, 8'h00, c});
  endtask
  // Also ends any run of reads, so no stray read overlaps the pulse
  task ev(input logic [17:0] r_i, input logic [5:0] s_i, input logic [1:0] u_i);
    @(posedge SYS_CLK); BUS_RD <= 1'b0; rc <= r_i; sn <= s_i; un <= u_i;
    @(posedge SYS_CLK); rc <= '0; sn <= '0; un <= '0;
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    rd_d <= BUS_RD;
    if (rd_d === 1'b1) begin
      expv = q.pop_front();
      `CHK({BUS_HIT, BUS_RDATA}, expv)
    end
  end
  initial begin
    repeat (4) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd(RST_CAUSE_OFFSET, 8'h02, 1'b1); rd(RST_CAUSE_OFFSET, 8'h00, 1'b1); ev(0, 0, 0);
    $display("test boot done");
    for (i = 0; i < 6; i++) begin
      r = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      ev(r[17:0], r[23:18], r[25:24]); rd(16'h0158, 8'h00, 1'b0); rd(16'h0160, 8'h00, 1'b0);
      for (int k = 0; k < RST_N; k++) if (r[k] && RST_VALID_MASK[k]) rd(RST_CAUSE_OFFSET, 8'(2 * (k + 1)), 1'b1);
      rd(RST_CAUSE_OFFSET, 8'h00, 1'b1);
      for (int k = 0; k < 6; k++) if (r[18 + k]) rd(SYS_NMI_OFFSET, sc[k], 1'b1);
      rd(SYS_NMI_OFFSET, 8'h00, 1'b1);
      for (int k = 0; k < 2; k++) if (r[24 + k]) rd(USER_NMI_OFFSET, 8'(2 * (k + 1)), 1'b1);
      rd(USER_NMI_OFFSET, 8'h00, 1'b1); ev(0, 0, 0);
    end
    $display("test priority drain done");
    ev(0, 6'h01, 2'b01); rd(SYS_NMI_OFFSET, 8'h02, 1'b1); rd(SYS_NMI_OFFSET, 8'h00, 1'b1);
    // Pin pulse lands on the same edge as the clearing read, so the flag stays
    rd(USER_NMI_OFFSET, 8'h02, 1'b1); un <= 2'b01;
    rd(USER_NMI_OFFSET, 8'h02, 1'b1); un <= 2'b00; rd(USER_NMI_OFFSET, 8'h00, 1'b1); ev(0, 0, 0);
    `CHK({SYS_NMI_PENDING, USER_NMI_PENDING}, 2'b00)
    $display("test set over clear done");
    RST <= 1'b1; repeat (3) @(posedge SYS_CLK); RST <= 1'b0;
    rd(RST_CAUSE_OFFSET, 8'h02, 1'b1); rd(RST_CAUSE_OFFSET, 8'h00, 1'b1); ev(0, 0, 0);
    $display("test second reset done");
    for (i = 0; i < 20 && q.size() != 0; i++) @(posedge SYS_CLK);
    if (q.size() != 0) begin n_mismatch++; $display("Error at %0t: results missing", $time); end
    close_out();
  end
endmodule
`default_nettype wire
